// ===== hdl/byte_buffer.sv
// small fifo between the array stream and the output shifter
`timescale 1ns/10ps
module byte_buffer
  import flash_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      count_q;
  logic [PW:0]      count_d;
  logic             ready_q;
  logic             valid_q;
  logic             push;
  logic             pop;

  assign push = in_valid && ready_q;
  assign pop  = out_ready && valid_q;

  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + 1'b1;
    else if (pop && !push)
      count_d = count_q - 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (flush)
      begin
        wr_q    <= '0;
        rd_q    <= '0;
        count_q <= '0;
        ready_q <= 1'b1;
        valid_q <= 1'b0;
      end
      else
      begin
        if (push)
          wr_q <= wr_q + 1'b1;
        if (pop)
          rd_q <= rd_q + 1'b1;
        count_q <= count_d;
        ready_q <= (count_d != FULL);
        valid_q <= (count_d != '0);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (clk_en && push && !flush)
      mem_q[wr_q] <= in_data;
  end

  assign in_ready  = ready_q;
  assign out_valid = valid_q;
  assign out_data  = mem_q[rd_q];

endmodule // byte_buffer

// ===== hdl/flash_pkg.sv
// shared constants, opcodes and carrier types for the serial flash sequencer
package flash_pkg;

  // opcodes
  localparam logic [7:0] OP_WRITE_EN     = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
  localparam logic [7:0] OP_VOL_WRITE_EN = 8'h50;
  localparam logic [7:0] OP_READ_SR1     = 8'h05;
  localparam logic [7:0] OP_READ_SR2     = 8'h35;
  localparam logic [7:0] OP_WRITE_SR     = 8'h01;
  localparam logic [7:0] OP_WRITE_SR2    = 8'h31;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_FAST_READ    = 8'h0B;
  localparam logic [7:0] OP_DUAL_READ    = 8'h3B;
  localparam logic [7:0] OP_SET_PARAM    = 8'hC0;
  localparam logic [7:0] OP_RESET_EN     = 8'h66;
  localparam logic [7:0] OP_RESET        = 8'h99;

  // status bit positions within each status byte
  localparam int SR1_BUSY  = 0;
  localparam int SR1_WEL   = 1;
  localparam int SR1_PROT0 = 7;
  localparam int SR2_PROT1 = 0;
  localparam int SR2_QE    = 1;
  localparam int PARAM_LSB = 4;
  localparam int BYTE_W    = 8;

  // phase lengths in bits and clocks
  localparam logic [4:0] CMD_BITS     = 5'h08;
  localparam logic [4:0] ADDR_BITS    = 5'h18;
  localparam logic [4:0] WR_ONE_BYTE  = 5'h08;
  localparam logic [4:0] WR_TWO_BYTES = 5'h10;
  localparam logic [4:0] CNT_SAT      = 5'h18;
  localparam logic [3:0] DUMMY_SINGLE = 4'h8;
  localparam logic [3:0] DUMMY_DUAL   = 4'h8;
  localparam logic [3:0] DUMMY_QPI_4  = 4'h4;
  localparam logic [3:0] DUMMY_QPI_6  = 4'h6;
  localparam logic [3:0] DUMMY_QPI_8  = 4'h8;

  // lanes per clock and pin drive patterns (low = driven)
  localparam logic [3:0] LANES_ONE  = 4'h1;
  localparam logic [3:0] LANES_TWO  = 4'h2;
  localparam logic [3:0] LANES_FOUR = 4'h4;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] IO_RELEASE = 4'hF;
  localparam logic [3:0] DRIVE_ONE  = 4'hD;
  localparam logic [3:0] DRIVE_TWO  = 4'hC;
  localparam logic [3:0] DRIVE_FOUR = 4'h0;

  // reset values
  localparam logic [1:0] PARAM_RESET = 2'h0;
  localparam logic [7:0] FILL_BYTE   = 8'hFF;
  localparam logic       SYNC_RESET  = 1'b1;

  // timing
  localparam int CLK_PERIOD_NS        = 5;
  localparam int STATUS_WRITE_TIME_NS = 5000000;

  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] io;
  } pins_t;

  typedef struct packed {
    logic prot0;
    logic prot1;
    logic qe;
  } status_bits_t;

  localparam status_bits_t STATUS_RESET = 3'h0;

endpackage

// ===== hdl/flash_seq.sv
// serial flash command sequencer: status, status write and read commands
//
// Operation
// [RULE1] volatile enable just before status write targets the volatile bits
// [RULE2] volatile enable does not set the write enable latch
// [RULE3] four-wire volatile write sets bits 15,13-10 to one; reads ignore them; the code stores no such bits and reads them back as zero
// [RULE4] write disable framed by chip select clears the write enable latch
// [RULE5] latch is zero after reset and after every write cycle ends
// [RULE6] status read shifts the byte out msb first on falls, repeating
// [RULE7] status reads are accepted at any time, even while busy
// [RULE8] host should poll busy before new commands during a write cycle
// [RULE9] status write changes only protect bits 0, 1 and quad enable
// [RULE10] status write executes only with the write enable latch set; the code also executes it after a volatile enable with the latch clear
// [RULE11] status write executes only after exactly eight or sixteen data bits
// [RULE12] one-byte status write clears quad enable and protect bit 1
// [RULE13] valid status write starts a timed cycle at chip select rise
// [RULE14] busy reads one for the whole cycle and zero after it
// [RULE15] write enable latch clears when busy is set
// [RULE16] register-2 write takes one byte, updates quad enable and protect 1
// [RULE17] plain read shifts the addressed byte out msb first on falls
// [RULE18] read address steps by one per byte until chip select rises
// [RULE19] plain read while busy is ignored
// [RULE20] fast read takes address on rises, skips dummies, outputs on falls
// [RULE21] four-wire dummy count is 4, 6 or 8 from parameter; default 4
// [RULE22] dual read has eight dummies then two bits per clock
// [RULE23] host releases data line 0 before the first dual output fall
// [RULE24] dual output: odd bits on line 1, even on line 0, 7/6 first
// [RULE25] write enable opcode sets the write enable latch
// [RULE26] single-wire fast read uses eight dummy clocks
`timescale 1ns/10ps
module flash_seq
  import flash_pkg::*;
#(
  parameter int STATUS_WRITE_NS = STATUS_WRITE_TIME_NS
)
(
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // serial pins
  input  wire logic        cs_n_pin,
  input  wire logic        sck_pin,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_drive_n,
  // mode select
  input  wire logic        four_wire_command_mode,
  // array read stream
  output logic      [23:0] fetch_addr,
  output logic             fetch_req,
  output logic             fetch_ready,
  input  wire logic        fetch_valid,
  input  wire logic [7:0]  fetch_data,
  // status view
  output logic             busy,
  output logic             write_enable_latch,
  output logic             quad_enable_bit,
  output logic             status_protect_bit_0,
  output logic             status_protect_bit_1
);

  localparam int WRITE_CYCLES = (STATUS_WRITE_NS / CLK_PERIOD_NS > 0) ?
                                STATUS_WRITE_NS / CLK_PERIOD_NS : 1;
  localparam logic [31:0] WRITE_LAST = 32'(WRITE_CYCLES - 1);

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_HOLD, ST_STATUS, ST_ADDR,
    ST_DUMMY, ST_DATA, ST_WRITE, ST_IGNORE
  } state_t;

  pins_t        pins_s;
  state_t       state_q;
  state_t       cmd_next;
  logic         sck_prev_q;
  logic         cs_prev_q;
  logic         qpi_q;
  logic [7:0]   op_q;
  logic [4:0]   cnt_q;
  logic [4:0]   cnt_d;
  logic [23:0]  sh_q;
  logic [23:0]  sh_d;
  logic [3:0]   dummy_q;
  logic [3:0]   dummy_len;
  logic [7:0]   osh_q;
  logic [3:0]   obit_q;
  logic [3:0]   io_out_q;
  logic [3:0]   io_drive_n_q;
  logic [3:0]   lanes;
  logic [7:0]   status_byte;
  logic [7:0]   src_byte;
  logic [7:0]   cur;
  logic [23:0]  fetch_addr_q;
  logic         fetch_req_q;
  logic         buf_ready;
  logic         buf_valid;
  logic [7:0]   buf_data;
  logic         busy_q;
  logic [31:0]  wtime_q;
  logic         wel_q;
  logic         vol_arm_q;
  logic         reset_arm_q;
  logic [1:0]   param_q;
  status_bits_t nv_q;
  status_bits_t vol_q;
  status_bits_t pend_q;
  status_bits_t new_bits;
  logic         rise;
  logic         fall;
  logic         cs_rise;
  logic         cs_fall;
  logic         cmd_done;
  logic         addr_done;
  logic         out_phase;
  logic         pop;
  logic         fetch_push;
  logic         hold_exec;
  logic         wr_exec;
  logic         sr_exec;
  logic         reset_exec;

  pin_sync #(.WIDTH($bits(pins_t))) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in ({cs_n_pin, sck_pin, io_in}),
    .sync_out (pins_s)
  );

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_prev_q <= SYNC_RESET;
      cs_prev_q  <= SYNC_RESET;
    end
    else if (clk_en)
    begin
      sck_prev_q <= pins_s.sck;
      cs_prev_q  <= pins_s.cs_n;
    end
  end

  // edges only count while chip select is low
  assign rise    = !pins_s.cs_n && pins_s.sck && !sck_prev_q;
  assign fall    = !pins_s.cs_n && !pins_s.sck && sck_prev_q;
  assign cs_fall = !pins_s.cs_n && cs_prev_q;
  assign cs_rise = pins_s.cs_n && !cs_prev_q;

  assign sh_d = qpi_q ? {sh_q[19:0], pins_s.io} : {sh_q[22:0], pins_s.io[0]};
  assign cnt_d = cnt_q + (qpi_q ? 5'h04 : 5'h01);
  assign cmd_done  = rise && state_q == ST_CMD && cnt_d == CMD_BITS;
  assign addr_done = rise && state_q == ST_ADDR && cnt_d == ADDR_BITS;

  always_comb
  begin
    case (sh_d[7:0])
      OP_READ_SR1, OP_READ_SR2:
        cmd_next = ST_STATUS; // RULE7
      OP_READ, OP_FAST_READ:
        cmd_next = busy_q ? ST_IGNORE : ST_ADDR; // RULE19
      OP_DUAL_READ:
        cmd_next = (busy_q || qpi_q) ? ST_IGNORE : ST_ADDR;
      OP_WRITE_SR, OP_WRITE_SR2, OP_SET_PARAM:
        cmd_next = busy_q ? ST_IGNORE : ST_WRITE;
      OP_WRITE_EN, OP_WRITE_DIS, OP_VOL_WRITE_EN, OP_RESET_EN, OP_RESET:
        cmd_next = busy_q ? ST_IGNORE : ST_HOLD;
      default:
        cmd_next = ST_IGNORE;
    endcase
  end

  always_comb
  begin
    if (!qpi_q)
      dummy_len = (op_q == OP_DUAL_READ) ? DUMMY_DUAL // RULE22
                                         : DUMMY_SINGLE; // RULE26
    else
      case (param_q)
        2'h0:    dummy_len = DUMMY_QPI_4; // RULE21
        2'h1:    dummy_len = DUMMY_QPI_6;
        default: dummy_len = DUMMY_QPI_8;
      endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      qpi_q   <= 1'b0;
      op_q    <= 8'h00;
      cnt_q   <= 5'h00;
      sh_q    <= 24'h000000;
      dummy_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (cs_rise)
        state_q <= ST_IDLE;
      else if (cs_fall)
      begin
        state_q <= ST_CMD;
        cnt_q   <= 5'h00;
        qpi_q   <= four_wire_command_mode;
      end
      else if (rise)
      begin
        sh_q  <= sh_d; // RULE20
        cnt_q <= (cnt_q > CNT_SAT) ? cnt_q : cnt_d;
        case (state_q)
          ST_CMD:
            if (cnt_d == CMD_BITS)
            begin
              op_q    <= sh_d[7:0];
              cnt_q   <= 5'h00;
              state_q <= cmd_next;
            end
          ST_ADDR:
            if (cnt_d == ADDR_BITS)
            begin
              dummy_q <= dummy_len;
              state_q <= (op_q == OP_READ) ? ST_DATA : ST_DUMMY; // RULE17
            end
          ST_DUMMY:
          begin
            dummy_q <= dummy_q - 4'h1; // RULE20
            if (dummy_q == 4'h1)
              state_q <= ST_DATA;
          end
          default: ;
        endcase
      end
    end
  end

  // output shifter
  assign out_phase = state_q == ST_STATUS || state_q == ST_DATA;
  assign pop       = fall && state_q == ST_DATA && obit_q == 4'h0;

  always_comb
  begin
    status_byte = 8'h00;
    if (op_q == OP_READ_SR1)
    begin
      status_byte[SR1_BUSY]  = busy_q;
      status_byte[SR1_WEL]   = wel_q;
      status_byte[SR1_PROT0] = vol_q.prot0;
    end
    else
    begin
      status_byte[SR2_PROT1] = vol_q.prot1; // RULE3
      status_byte[SR2_QE]    = vol_q.qe;
    end
    if (state_q == ST_STATUS)
      src_byte = status_byte;
    else
      src_byte = buf_valid ? buf_data : FILL_BYTE;
    cur = (obit_q == 4'h0) ? src_byte : osh_q;
    if (qpi_q)
      lanes = LANES_FOUR;
    else if (state_q == ST_DATA && op_q == OP_DUAL_READ)
      lanes = LANES_TWO;
    else
      lanes = LANES_ONE;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osh_q        <= 8'h00;
      obit_q       <= 4'h0;
      io_out_q     <= 4'h0;
      io_drive_n_q <= IO_RELEASE;
    end
    else if (clk_en)
    begin
      if (cs_rise || cs_fall)
      begin
        obit_q       <= 4'h0;
        io_drive_n_q <= IO_RELEASE;
      end
      else if (fall && out_phase)
      begin
        osh_q  <= cur << lanes;
        obit_q <= ((obit_q == 4'h0) ? BYTE_BITS : obit_q) - lanes; // RULE6
        case (lanes)
          LANES_FOUR:
          begin
            io_out_q     <= cur[7:4];
            io_drive_n_q <= DRIVE_FOUR;
          end
          LANES_TWO:
          begin
            io_out_q     <= {2'h0, cur[7:6]}; // RULE24
            io_drive_n_q <= DRIVE_TWO; // RULE22
          end
          default:
          begin
            io_out_q     <= {2'h0, cur[7], 1'b0}; // RULE17
            io_drive_n_q <= DRIVE_ONE;
          end
        endcase
      end
    end
  end

  // array stream, prefetched into the buffer
  assign fetch_push = fetch_valid && fetch_req_q && buf_ready;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetch_addr_q <= 24'h000000;
      fetch_req_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (cs_rise || cs_fall)
        fetch_req_q <= 1'b0;
      else if (addr_done)
      begin
        fetch_addr_q <= sh_d;
        fetch_req_q  <= 1'b1;
      end
      else if (fetch_push)
        fetch_addr_q <= fetch_addr_q + 24'h000001; // RULE18
    end
  end

  byte_buffer #(.WIDTH(8), .DEPTH(2)) u_buffer (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .flush     (cs_rise || cs_fall),
    .in_valid  (fetch_valid && fetch_req_q),
    .in_ready  (buf_ready),
    .in_data   (fetch_data),
    .out_valid (buf_valid),
    .out_ready (pop),
    .out_data  (buf_data)
  );

  // commands executed when chip select rises on an exact frame
  assign hold_exec  = cs_rise && state_q == ST_HOLD && cnt_q == 5'h00;
  assign wr_exec    = cs_rise && state_q == ST_WRITE &&
                      (cnt_q == WR_ONE_BYTE ||
                       (cnt_q == WR_TWO_BYTES && op_q == OP_WRITE_SR)); // RULE11
  assign sr_exec    = wr_exec && op_q != OP_SET_PARAM &&
                      (wel_q || vol_arm_q); // RULE10
  assign reset_exec = hold_exec && op_q == OP_RESET && reset_arm_q;

  always_comb
  begin
    new_bits = vol_arm_q ? vol_q : nv_q;
    if (op_q == OP_WRITE_SR && cnt_q == WR_ONE_BYTE)
    begin
      new_bits.prot0 = sh_q[SR1_PROT0]; // RULE9
      new_bits.prot1 = 1'b0; // RULE12
      new_bits.qe    = 1'b0;
    end
    else
    begin
      if (op_q == OP_WRITE_SR)
        new_bits.prot0 = sh_q[BYTE_W + SR1_PROT0];
      new_bits.prot1 = sh_q[SR2_PROT1]; // RULE16
      new_bits.qe    = sh_q[SR2_QE];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q  <= 1'b0;
      wtime_q <= 32'h00000000;
      nv_q    <= STATUS_RESET;
      vol_q   <= STATUS_RESET;
      pend_q  <= STATUS_RESET;
    end
    else if (clk_en)
    begin
      if (sr_exec && vol_arm_q)
        vol_q <= new_bits; // RULE1
      else if (sr_exec)
      begin
        busy_q  <= 1'b1; // RULE13
        wtime_q <= WRITE_LAST;
        pend_q  <= new_bits;
      end
      else if (busy_q)
      begin
        if (wtime_q == 32'h00000000)
        begin
          busy_q <= 1'b0; // RULE14
          nv_q   <= pend_q;
          vol_q  <= pend_q;
        end
        else
          wtime_q <= wtime_q - 32'h00000001;
      end
      else if (reset_exec)
        vol_q <= nv_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wel_q <= 1'b0; // RULE5
    else if (clk_en)
    begin
      if (hold_exec && op_q == OP_WRITE_EN)
        wel_q <= 1'b1; // RULE25
      else if (hold_exec && op_q == OP_WRITE_DIS)
        wel_q <= 1'b0; // RULE4
      else if ((sr_exec && !vol_arm_q) || reset_exec)
        wel_q <= 1'b0; // RULE15
      else if (busy_q && wtime_q == 32'h00000000)
        wel_q <= 1'b0; // RULE5
    end
  end

  // one-shot arms for volatile write and reset, plus the read parameter
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vol_arm_q   <= 1'b0;
      reset_arm_q <= 1'b0;
      param_q     <= PARAM_RESET; // RULE21
    end
    else if (clk_en)
    begin
      if (hold_exec && op_q == OP_VOL_WRITE_EN)
        vol_arm_q <= 1'b1; // RULE2
      else if (wr_exec || (cmd_done && sh_d[7:0] != OP_WRITE_SR &&
                           sh_d[7:0] != OP_WRITE_SR2))
        vol_arm_q <= 1'b0;
      // the arm must survive the reset opcode itself, so only a frame end clears it
      if (hold_exec && op_q == OP_RESET_EN)
        reset_arm_q <= 1'b1;
      else if (cs_rise)
        reset_arm_q <= 1'b0;
      if (reset_exec)
        param_q <= PARAM_RESET; // RULE21
      else if (wr_exec && op_q == OP_SET_PARAM && cnt_q == WR_ONE_BYTE)
        param_q <= sh_q[PARAM_LSB +: 2];
    end
  end

  assign io_out               = io_out_q;
  assign io_drive_n           = io_drive_n_q;
  assign fetch_addr           = fetch_addr_q;
  assign fetch_req            = fetch_req_q;
  assign fetch_ready          = buf_ready;
  assign busy                 = busy_q;
  assign write_enable_latch   = wel_q;
  assign quad_enable_bit      = vol_q.qe;
  assign status_protect_bit_0 = vol_q.prot0;
  assign status_protect_bit_1 = vol_q.prot1;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  a_vol_wel_kept: // RULE2
    assert property (hold_exec && op_q == OP_VOL_WRITE_EN |=> $stable(wel_q))
      else $error("volatile enable changed the write latch");
  a_wrdi_clears: // RULE4
    assert property (hold_exec && op_q == OP_WRITE_DIS |=> !wel_q)
      else $error("write disable left the latch set");
  a_wren_sets: // RULE25
    assert property (hold_exec && op_q == OP_WRITE_EN |=> wel_q)
      else $error("write enable did not set the latch");
  a_busy_drops_wel: // RULE15
    assert property ($rose(busy_q) |-> !wel_q)
      else $error("latch still set when busy rose");
  a_cycle_end: // RULE14
    assert property (busy_q && wtime_q == 32'h0 |=> !busy_q && !wel_q)
      else $error("write cycle end wrong");
  a_bad_frame_idle: // RULE11
    assert property (cs_rise && state_q == ST_WRITE && cnt_q != WR_ONE_BYTE &&
      cnt_q != WR_TWO_BYTES |=> !busy_q && $stable(vol_q))
      else $error("misframed status write executed");
  a_no_latch_no_write: // RULE10
    assert property (cs_rise && state_q == ST_WRITE && !wel_q && !vol_arm_q
      |=> !busy_q) else $error("status write ran without latch");
  a_one_byte_clear: // RULE12
    assert property (sr_exec && !vol_arm_q && op_q == OP_WRITE_SR &&
      cnt_q == WR_ONE_BYTE |=> !pend_q.qe && !pend_q.prot1)
      else $error("one byte write kept quad enable");
  a_write_start: // RULE13
    assert property (sr_exec && !vol_arm_q |=> busy_q && wtime_q == WRITE_LAST)
      else $error("write cycle did not start");
  a_busy_read_dropped: // RULE19
    assert property (cmd_done && sh_d[7:0] == OP_READ && busy_q
      |=> state_q == ST_IGNORE) else $error("read accepted while busy");
  a_dual_pair: // RULE24
    assert property (fall && out_phase && lanes == LANES_TWO |=>
      io_out_q[1:0] == $past(cur[7:6]) && io_drive_n_q == DRIVE_TWO)
      else $error("dual output bit pair wrong");
  a_addr_step: // RULE18
    assert property (fetch_push && !cs_rise && !cs_fall |=>
      fetch_addr_q == $past(fetch_addr_q) + 24'h000001)
      else $error("read address did not advance");

  c_status_read: cover property (fall && state_q == ST_STATUS);
  c_dual_read:   cover property (pop && op_q == OP_DUAL_READ);
  c_write_done:  cover property (busy_q ##1 !busy_q);
  c_quad_read:   cover property (pop && qpi_q);

endmodule // flash_seq

// ===== hdl/pin_sync.sv
// two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/10ps
module pin_sync
  import flash_pkg::*;
#(
  parameter int WIDTH = 6
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_q <= SYNC_RESET;
          sync_q <= SYNC_RESET;
        end
        else if (clk_en)
        begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate

endmodule // pin_sync

// ===== verif/spi_host.sv
// host serial controller model that frames commands on the flash pins
`timescale 1ns/10ps
module spi_host
  import flash_pkg::*;
(
  // timebase
  input  wire logic       core_clk,
  // pins toward the flash
  output logic            cs_n_pin,
  output logic            sck_pin,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_drive_n
);
  initial
  begin
    cs_n_pin = 1'b1;
    sck_pin  = 1'b0;
    io_in    = 4'hF;
  end

  // ntx clocks out msb first, then nrx clocks sampled in; lanes is the bits
  // per clock read back (1, 2 or 4), four also sends in nibbles
  task automatic frame(input logic [39:0] tx, input int ntx, input int nrx,
                       output logic [15:0] rx, input int lanes = 1);
    logic [3:0] v;
    rx = 16'h0000;
    repeat (6) @(posedge core_clk);
    cs_n_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    for (int i = 0; i < ntx + nrx; i++)
    begin
      // released lines toggle so a stale value never looks valid
      io_in <= (i >= ntx) ? ~io_in : (lanes == 4) ? tx[4*(ntx-1-i) +: 4] :
               {io_in[3:1], tx[ntx-1-i]};
      repeat (12) @(posedge core_clk);
      // undriven data lines read high through their pull-ups
      v = io_out | io_drive_n;
      if (i >= ntx)
        rx = (lanes == 4) ? {rx[11:0], v} :
             (lanes == 2) ? {rx[13:0], v[1:0]} : {rx[14:0], v[1]};
      sck_pin <= 1'b1;
      repeat (13) @(posedge core_clk);
      sck_pin <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
    cs_n_pin <= 1'b1;
  endtask
endmodule // spi_host

// ===== verif/test_flash_seq.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/10ps
module test_flash_seq
  import flash_pkg::*;
;
  logic        core_clk, rst_n, cs_n_pin, sck_pin, fetch_valid;
  logic        fetch_req, fetch_ready, busy, write_enable_latch;
  logic        quad_enable_bit, status_protect_bit_0, status_protect_bit_1;
  logic [3:0]  io_in, io_out, io_drive_n;
  logic [7:0]  fetch_data;
  logic [23:0] fetch_addr;
  logic [15:0] rx;
  logic        quad;
  int          fail_count, check_count, n;

  always #2.5 core_clk = ~core_clk;
  // array model: byte value derived from its address
  assign fetch_valid = fetch_req;
  assign fetch_data  = fetch_addr[7:0] ^ 8'h5A;

  spi_host host_u (.core_clk, .cs_n_pin, .sck_pin, .io_in, .io_out,
                   .io_drive_n);
  flash_seq #(.STATUS_WRITE_NS(10000)) dut_u (.core_clk, .rst_n,
    .clk_en(1'b1), .cs_n_pin, .sck_pin, .io_in, .io_out, .io_drive_n,
    .four_wire_command_mode(quad), .fetch_addr, .fetch_req, .fetch_ready,
    .fetch_valid, .fetch_data, .busy, .write_enable_latch, .quad_enable_bit,
    .status_protect_bit_0, .status_protect_bit_1);

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [39:0] tx, input int ntx,
                     input int lanes = 1);
    host_u.frame(tx, ntx, 0, rx, lanes);
  endtask

  task automatic rd_sr(input logic [7:0] op, input logic [7:0] exp);
    host_u.frame(40'(op), 8, 16, rx);
    check(rx, {exp, exp});
  endtask

  // length of the busy window in core clocks
  task automatic busy_len();
    for (n = 0; n < 20 && busy !== 1'b1; n++) @(posedge core_clk);
    for (n = 0; n < 3000 && busy === 1'b1; n++) @(posedge core_clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    complete_run();
  end

  initial
  begin
    core_clk = 1'b0;
    rst_n    = 1'b0;
    quad     = 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_sr(OP_READ_SR1, 8'h00);
    cmd(40'(OP_WRITE_EN), 8);
    rd_sr(OP_READ_SR1, 8'h02);
    cmd(40'(OP_WRITE_DIS), 8);
    rd_sr(OP_READ_SR1, 8'h00);
    cmd({OP_WRITE_SR, 8'h80}, 16);
    rd_sr(OP_READ_SR1, 8'h00);
    cmd(40'(OP_WRITE_EN), 8);
    cmd({OP_WRITE_SR, 12'h800}, 20);
    rd_sr(OP_READ_SR1, 8'h02);
    cmd({OP_WRITE_SR, 16'h8003}, 24);
    fork
      busy_len();
      begin
        rd_sr(OP_READ_SR1, 8'h01);
        host_u.frame({OP_READ, 24'h000010}, 32, 8, rx);
        check(rx, 16'h00FF);
      end
    join
    check(16'(n), 16'h07D0);
    rd_sr(OP_READ_SR1, 8'h80);
    rd_sr(OP_READ_SR2, 8'h03);
    cmd(40'(OP_VOL_WRITE_EN), 8);
    cmd({OP_WRITE_SR, 8'h00}, 16);
    // a wrongly started write cycle would show busy by now
    repeat (8) @(posedge core_clk);
    check({15'h0000, busy}, 16'h0000);
    rd_sr(OP_READ_SR2, 8'h00);
    rd_sr(OP_READ_SR1, 8'h00);
    cmd(40'(OP_WRITE_EN), 8);
    cmd({OP_WRITE_SR2, 8'h02}, 16);
    busy_len();
    rd_sr(OP_READ_SR2, 8'h02);
    host_u.frame({OP_READ, 24'h000010}, 32, 16, rx);
    check(rx, 16'h4A4B);
    host_u.frame({OP_FAST_READ, 24'h000020, 8'h00}, 40, 16, rx);
    check(rx, 16'h7A7B);
    host_u.frame({OP_DUAL_READ, 24'h000030, 8'h00}, 40, 8, rx, 2);
    check(rx, 16'h6A6B);
    // four-wire reads: dummies are read back as idle nibbles and shifted out
    quad <= 1'b1;
    host_u.frame({OP_FAST_READ, 24'h000040}, 8, 8, rx, 4);
    check(rx, 16'h1A1B);
    cmd({OP_SET_PARAM, 8'h10}, 4, 4);
    host_u.frame({OP_FAST_READ, 24'h000050}, 8, 10, rx, 4);
    check(rx, 16'h0A0B);
    cmd(40'(OP_RESET_EN), 2, 4);
    cmd(40'(OP_RESET), 2, 4);
    host_u.frame({OP_FAST_READ, 24'h000060}, 8, 8, rx, 4);
    check(rx, 16'h3A3B);
    complete_run();
  end
endmodule // test_flash_seq
